// ### hw/nand_host_pkg.sv
// Purpose: shared constants for the flash host sequencer (timing, status bits, op codes)
// Assumes: 20 MHz system clock, x8 multiplexed flash bus
// Notes:   timing figures are in ns and converted to whole clock cycles here
package nand_host_pkg;

  localparam int CLK_NS      = 50;
  // least strobe and hold widths, rounded up to whole cycles
  localparam int SETUP_NS    = 25;
  localparam int STROBE_NS   = 25;
  localparam int HOLD_NS     = 25;
  localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // write strobe high to busy low, and to first read strobe
  localparam int BUSY_SET_NS  = 100;
  localparam int BUSY_SET_CYC = (BUSY_SET_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_NS       = 60;
  localparam int WHR_CYC      = (WHR_NS + CLK_NS - 1) / CLK_NS;

  // status byte layout
  localparam int ST_UNPROT     = 7;
  localparam int ST_CACHE_RDY  = 6;
  localparam int ST_ARRAY_RDY  = 5;
  localparam int ST_PRIOR_FAIL = 1;
  localparam int ST_FAIL       = 0;
  localparam logic [7:0] ST_USED_MASK = 8'hE3;

  localparam int ADDR_FULL_CYCLES  = 5;
  localparam int ADDR_BLOCK_CYCLES = 3;

  typedef enum logic [2:0] {
    OP_CACHE_PAGE  = 3'h0,  // page, cache confirm, session continues
    OP_CACHE_END10 = 3'h1,  // last page, normal program confirm
    OP_CACHE_END15 = 3'h2,  // last page, cache confirm, then poll
    OP_ERASE       = 3'h3,
    OP_RESET       = 3'h4,
    OP_STATUS      = 3'h5
  } op_type;

endpackage

// ### hw/nand_cycle_engine.sv
// Purpose: one bus cycle on the flash pins: command, address or data write, or a data read
// Assumes: chip enable is handled by the caller; pin inputs synchronous to clk_i
// Notes:   request is a level; a new cycle starts only when done_o is low
`timescale 1ns/1ps
`default_nettype none
module nand_cycle_engine (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       req_i,
  input  wire logic       read_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic [7:0] byte_i,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic            cle_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic            re_n_o,
  output logic [7:0]      io_o,
  output logic            io_oe_o,
  input  wire logic [7:0] io_i
);

  typedef enum logic [1:0] {
    B_IDLE   = 2'h0,
    B_SETUP  = 2'h1,
    B_STROBE = 2'h2,
    B_HOLD   = 2'h3
  } phase_type;

  phase_type  phase;
  logic [3:0] cnt;
  logic       rd;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase   <= B_IDLE;
      cnt     <= 4'h0;
      rd      <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 8'h00;
      cle_o   <= 1'b0;
      ale_o   <= 1'b0;
      we_n_o  <= 1'b1;
      re_n_o  <= 1'b1;
      io_o    <= 8'h00;
      io_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (phase)
        B_IDLE: begin
          if (req_i && !done_o) begin
            rd      <= read_i;
            cle_o   <= cle_i & ~read_i;
            ale_o   <= ale_i & ~read_i;
            io_o    <= byte_i;
            io_oe_o <= ~read_i;
            cnt     <= 4'(nand_host_pkg::SETUP_CYC - 1);
            phase   <= B_SETUP;
          end
        end
        B_SETUP: begin
          if (cnt == 4'h0) begin
            we_n_o <= rd;
            re_n_o <= ~rd;
            cnt    <= 4'(nand_host_pkg::STROBE_CYC - 1);
            phase  <= B_STROBE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        B_STROBE: begin
          if (cnt == 4'h0) begin
            // device latches on the rising write strobe; read data sampled before release
            we_n_o <= 1'b1;
            re_n_o <= 1'b1;
            if (rd) begin
              rdata_o <= io_i;
            end
            cnt   <= 4'(nand_host_pkg::HOLD_CYC - 1);
            phase <= B_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        B_HOLD: begin
          if (cnt == 4'h0) begin
            cle_o   <= 1'b0;
            ale_o   <= 1'b0;
            io_oe_o <= 1'b0;
            done_o  <= 1'b1;
            phase   <= B_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### hw/nand_cache_host.sv
// Purpose: host sequencer for cache program, block erase, reset and status polling
// Assumes: one flash die on an x8 bus; orders arrive one at a time at op_valid_i
// Notes:   the status byte is read after every program or erase for its fail bits
`timescale 1ns/1ps
`default_nettype none
module nand_cache_host #(
  parameter int         MAX_PAGE_BYTES  = 2112,
  parameter int         MAX_CACHE_PAGES = 64,
  parameter int         PAGE_BITS       = 6,
  parameter logic [7:0] CMD_PROG_SETUP  = 8'h80,
  parameter logic [7:0] CMD_PROG_END    = 8'h10,
  parameter logic [7:0] CMD_CACHE_END   = 8'h15,
  parameter logic [7:0] CMD_ERASE_SETUP = 8'h60,
  parameter logic [7:0] CMD_ERASE_END   = 8'hD0,
  parameter logic [7:0] CMD_RESET       = 8'hFF,
  parameter logic [7:0] CMD_STATUS      = 8'h70
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        op_valid_i,
  input  wire logic [2:0]  op_code_i,
  input  wire logic [23:0] row_i,
  input  wire logic [15:0] col_i,
  input  wire logic [11:0] length_i,
  input  wire logic        write_enable_i,
  output logic             op_ready_o,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  output logic             done_o,
  output logic             refused_o,
  output logic [7:0]       status_o,
  output logic             fail_o,
  output logic             prior_fail_o,
  output logic             protected_o,
  output logic             ce_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             we_n_o,
  output logic             re_n_o,
  output logic             wp_n_o,
  output logic [7:0]       io_o,
  output logic             io_oe_o,
  input  wire logic [7:0]  io_i,
  input  wire logic        ready_busy_line_i
);

  if (MAX_PAGE_BYTES < 1 || MAX_PAGE_BYTES > 4095 || MAX_CACHE_PAGES < 1 ||
      MAX_CACHE_PAGES > 255 || PAGE_BITS < 1 || PAGE_BITS > 23) begin : g_bad_params
    $error("nand_cache_host: parameter out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_SETUP   = 4'h1,
    S_ADDR    = 4'h2,
    S_DATA    = 4'h3,
    S_CONFIRM = 4'h4,
    S_WAIT    = 4'h5,
    S_BUSY    = 4'h6,
    S_STCMD   = 4'h7,
    S_STREAD  = 4'h8,
    S_FINISH  = 4'h9
  } state_type;

  localparam logic [11:0] MAX_BYTES = 12'(MAX_PAGE_BYTES);
  localparam logic [7:0]  MAX_PAGES = 8'(MAX_CACHE_PAGES);

  state_type    state;
  nand_host_pkg::op_type op;
  logic [23:0]  row;
  logic [15:0]  col;
  logic [11:0]  len;
  logic [11:0]  data_cnt;
  logic [2:0]   addr_idx;
  logic [3:0]   wait_cnt;
  logic         polling;
  logic [7:0]   data_byte;
  logic         have_byte;
  logic         in_cache;
  logic [23:0]  block;
  logic [7:0]   page_cnt;
  logic         status_mode;
  logic         bus_req;
  logic         bus_read;
  logic         bus_cle;
  logic         bus_ale;
  logic [7:0]   bus_byte;
  logic         bus_done;
  logic [7:0]   bus_rdata;
  logic         is_erase;
  logic         is_cache;
  logic         new_block_ok;
  logic [23:0]  blk_of_row_i;

  function automatic logic [23:0] block_of(input logic [23:0] r);
    block_of = r >> PAGE_BITS;
  endfunction

  // erase sends only the three row bytes; page bits are don't care to the device
  function automatic logic [7:0] addr_byte(input logic er, input logic [2:0] i,
                                           input logic [15:0] c, input logic [23:0] r);
    logic [2:0] k;
    k = er ? i + 3'h2 : i;
    unique case (k)
      3'h0:    addr_byte = c[7:0];
      3'h1:    addr_byte = c[15:8];
      3'h2:    addr_byte = r[7:0];
      3'h3:    addr_byte = r[15:8];
      default: addr_byte = r[23:16];
    endcase
  endfunction

  assign is_erase     = (op == nand_host_pkg::OP_ERASE);
  assign is_cache     = (op == nand_host_pkg::OP_CACHE_PAGE) ||
                        (op == nand_host_pkg::OP_CACHE_END10) ||
                        (op == nand_host_pkg::OP_CACHE_END15);
  assign blk_of_row_i = block_of(row_i);
  // a new page may join the session only in the same block and under the page limit
  assign new_block_ok = !in_cache ||
                        ((blk_of_row_i == block) && (page_cnt < MAX_PAGES));

  always_comb begin
    bus_req  = 1'b0;
    bus_read = 1'b0;
    bus_cle  = 1'b0;
    bus_ale  = 1'b0;
    bus_byte = 8'h00;
    unique case (state)
      S_SETUP: begin
        bus_req  = 1'b1;
        bus_cle  = 1'b1;
        bus_byte = (op == nand_host_pkg::OP_RESET) ? CMD_RESET :
                   is_erase ? CMD_ERASE_SETUP : CMD_PROG_SETUP;
      end
      S_ADDR: begin
        bus_req  = 1'b1;
        bus_ale  = 1'b1;
        bus_byte = addr_byte(is_erase, addr_idx, col, row);
      end
      S_DATA: begin
        bus_req  = have_byte;
        bus_byte = data_byte;
      end
      S_CONFIRM: begin
        bus_req  = 1'b1;
        bus_cle  = 1'b1;
        bus_byte = is_erase ? CMD_ERASE_END :
                   (op == nand_host_pkg::OP_CACHE_END10) ? CMD_PROG_END : CMD_CACHE_END;
      end
      S_STCMD: begin
        bus_req  = 1'b1;
        bus_cle  = 1'b1;
        bus_byte = CMD_STATUS;
      end
      S_STREAD: begin
        bus_req  = 1'b1;
        bus_read = 1'b1;
      end
      default: begin
        bus_req = 1'b0;
      end
    endcase
  end

  nand_cycle_engine u_cycle (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .req_i    (bus_req),
    .read_i   (bus_read),
    .cle_i    (bus_cle),
    .ale_i    (bus_ale),
    .byte_i   (bus_byte),
    .done_o   (bus_done),
    .rdata_o  (bus_rdata),
    .cle_o    (cle_o),
    .ale_o    (ale_o),
    .we_n_o   (we_n_o),
    .re_n_o   (re_n_o),
    .io_o     (io_o),
    .io_oe_o  (io_oe_o),
    .io_i     (io_i)
  );

  // sequence control
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state     <= S_IDLE;
      op        <= nand_host_pkg::OP_STATUS;
      row       <= 24'h000000;
      col       <= 16'h0000;
      len       <= 12'h000;
      data_cnt  <= 12'h000;
      addr_idx  <= 3'h0;
      wait_cnt  <= 4'h0;
      polling   <= 1'b0;
      op_ready_o <= 1'b0;
      refused_o <= 1'b0;
      done_o    <= 1'b0;
      ce_n_o    <= 1'b1;
    end else begin
      refused_o  <= 1'b0;
      done_o     <= 1'b0;
      op_ready_o <= (state == S_IDLE) && !op_valid_i && !done_o && !refused_o;
      unique case (state)
        S_IDLE: begin
          if (op_valid_i && op_ready_o) begin
            op_ready_o <= 1'b0;
            op  <= nand_host_pkg::op_type'(op_code_i);
            row <= row_i;
            col <= col_i;
            len <= length_i;
            data_cnt <= 12'h000;
            addr_idx <= 3'h0;
            polling  <= 1'b0;
            if (op_code_i > 3'(nand_host_pkg::OP_STATUS)) begin
              refused_o <= 1'b1;
            end else if (op_code_i <= 3'(nand_host_pkg::OP_CACHE_END15) &&
                         (!new_block_ok || length_i == 12'h000 ||
                          length_i > MAX_BYTES)) begin
              refused_o <= 1'b1;
            end else begin
              ce_n_o <= 1'b0;
              state  <= (op_code_i == 3'(nand_host_pkg::OP_STATUS)) ? S_STCMD : S_SETUP;
            end
          end
        end
        S_SETUP: begin
          if (bus_done) begin
            if (op == nand_host_pkg::OP_RESET) begin
              wait_cnt <= 4'(nand_host_pkg::BUSY_SET_CYC);
              state    <= S_WAIT;
            end else begin
              state <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (bus_done) begin
            addr_idx <= addr_idx + 3'h1;
            if (addr_idx == 3'(is_erase ? nand_host_pkg::ADDR_BLOCK_CYCLES - 1 :
                                          nand_host_pkg::ADDR_FULL_CYCLES - 1)) begin
              state <= is_erase ? S_CONFIRM : S_DATA;
            end
          end
        end
        S_DATA: begin
          if (bus_done) begin
            data_cnt <= data_cnt + 12'h001;
            if (data_cnt + 12'h001 == len) begin
              state <= S_CONFIRM;
            end
          end
        end
        S_CONFIRM: begin
          if (bus_done) begin
            wait_cnt <= 4'(nand_host_pkg::BUSY_SET_CYC);
            state    <= S_WAIT;
          end
        end
        S_WAIT: begin
          // busy may not show until some time after the confirm strobe rises
          if (wait_cnt == 4'h0) begin
            state <= polling ? S_STREAD : S_BUSY;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        S_BUSY: begin
          // cache transfer, array program, erase or reset busy; only status may follow
          if (ready_busy_line_i) begin
            state <= (op == nand_host_pkg::OP_RESET) ? S_FINISH : S_STCMD;
          end
        end
        S_STCMD: begin
          if (bus_done) begin
            polling  <= 1'b1;
            wait_cnt <= 4'(nand_host_pkg::WHR_CYC);
            state    <= S_WAIT;
          end
        end
        S_STREAD: begin
          // a cache-confirmed last page is finished only once array ready reads one
          if (bus_done) begin
            if (op == nand_host_pkg::OP_CACHE_END15 &&
                !bus_rdata[nand_host_pkg::ST_ARRAY_RDY]) begin
              state <= S_STREAD;
            end else begin
              state <= S_FINISH;
            end
          end
        end
        S_FINISH: begin
          ce_n_o <= 1'b1;
          done_o <= 1'b1;
          state  <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // write data handshake: one byte held at a time
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_byte  <= 8'h00;
      have_byte  <= 1'b0;
      wr_ready_o <= 1'b0;
    end else if (state == S_DATA) begin
      if (wr_valid_i && wr_ready_o) begin
        data_byte  <= wr_data_i;
        have_byte  <= 1'b1;
        wr_ready_o <= 1'b0;
      end else if (bus_done) begin
        have_byte  <= 1'b0;
        wr_ready_o <= (data_cnt + 12'h001 != len);
      end else if (!have_byte) begin
        wr_ready_o <= 1'b1;
      end
    end else begin
      have_byte  <= 1'b0;
      wr_ready_o <= 1'b0;
    end
  end

  // cache session bookkeeping
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_cache <= 1'b0;
      block    <= 24'h000000;
      page_cnt <= 8'h00;
    end else if (state == S_IDLE && op_valid_i && op_ready_o) begin
      if (op_code_i <= 3'(nand_host_pkg::OP_CACHE_END15) && new_block_ok &&
          length_i != 12'h000 && length_i <= MAX_BYTES) begin
        in_cache <= (op_code_i == 3'(nand_host_pkg::OP_CACHE_PAGE));
        block    <= blk_of_row_i;
        page_cnt <= (in_cache ? page_cnt : 8'h00) + 8'h01;
      end else if (op_code_i == 3'(nand_host_pkg::OP_ERASE) ||
                   op_code_i == 3'(nand_host_pkg::OP_RESET)) begin
        in_cache <= 1'b0;
        page_cnt <= 8'h00;
      end
    end
  end

  // status results and device status-mode tracking
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_o     <= 8'h00;
      fail_o       <= 1'b0;
      prior_fail_o <= 1'b0;
      protected_o  <= 1'b0;
      status_mode  <= 1'b0;
      wp_n_o       <= 1'b0;
    end else begin
      wp_n_o <= write_enable_i;
      if (bus_done && bus_cle) begin
        status_mode <= (bus_byte == CMD_STATUS);
      end
      if (state == S_STREAD && bus_done) begin
        status_o     <= bus_rdata & nand_host_pkg::ST_USED_MASK;
        fail_o       <= bus_rdata[nand_host_pkg::ST_FAIL];
        prior_fail_o <= is_cache & bus_rdata[nand_host_pkg::ST_PRIOR_FAIL];
        protected_o  <= ~bus_rdata[nand_host_pkg::ST_UNPROT];
      end else if (state == S_FINISH && op == nand_host_pkg::OP_RESET) begin
        status_o     <= 8'h00;
        fail_o       <= 1'b0;
        prior_fail_o <= 1'b0;
      end
    end
  end

  AST_SAME_BLOCK: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state == S_ADDR && is_cache)
      |-> (block_of(row) == block))
    else $error("cache page outside the session block");

  AST_CONFIRM_AFTER_DATA: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state == S_CONFIRM && !is_erase) |-> (data_cnt == len && len <= MAX_BYTES))
    else $error("program confirm before all data bytes were sent");

  AST_END15_POLLED: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && op == nand_host_pkg::OP_CACHE_END15) |-> status_o[nand_host_pkg::ST_ARRAY_RDY])
    else $error("cache-confirmed end finished without array ready");

  AST_PAGE_LIMIT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(state == S_SETUP) && is_cache |-> ##1 (page_cnt <= MAX_PAGES && page_cnt != 8'h00))
    else $error("cache session page count out of range");

  AST_ERASE_ADDR_COUNT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($past(state) == S_ADDR && state == S_CONFIRM)
      |-> (is_erase && addr_idx == 3'(nand_host_pkg::ADDR_BLOCK_CYCLES)))
    else $error("erase confirm not after three block address cycles");

  AST_BUSY_ONLY_STATUS: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state == S_BUSY && !ready_busy_line_i) |=> (!bus_req || state == S_STCMD))
    else $error("command other than status issued while device busy");

  AST_READ_IN_STATUS_MODE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state == S_STREAD) |-> status_mode)
    else $error("status read without the device in status mode");

  AST_PRIOR_FAIL_MASKED: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (done_o && !is_cache) |-> !prior_fail_o)
    else $error("prior page fail reported outside cache programming");

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(done_o) |-> (status_o & ~nand_host_pkg::ST_USED_MASK) == 8'h00 ##1 !done_o)
    else $error("reserved status bits passed through");

endmodule
`default_nettype wire

// ### verif/nand_dev_model.sv
// Purpose: behavioural flash die that answers the host sequencer's bus cycles
// Assumes: strobes change on clk_i edges; busy times are short cycle counts
// Notes:   reserved and undefined status bits read 1 to catch a host trusting them
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model (
  input  wire logic       clk_i,
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic       wp_n_i,
  input  wire logic       fail_i,
  input  wire logic [7:0] io_i,
  output logic [7:0]      io_o,
  output logic            rb_o,
  output var int          bytes_o,
  output var int          addr_o
);
  logic       we_q = 1'b1;
  logic       stat_mode = 1'b0;
  logic       in_rst = 1'b0;
  logic       cache = 1'b0;
  logic       pf = 1'b0;
  logic       cf = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] stat;
  int         busy = 0;
  int         arr = 0;
  assign stat = {wp_n_i, busy == 0, arr == 0, 3'h7, cache ? pf : 1'b1, cf};
  assign rb_o = (busy == 0);
  // a released bus shows the inverse of the last byte
  assign io_o = (!ce_n_i && !re_n_i && stat_mode) ? stat : ~last;
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    if (busy > 0) busy <= busy - 1;
    if (arr > 0) arr <= arr - 1;
    if (!re_n_i) last <= io_o;
    if (we_n_i && !we_q && !ce_n_i) begin
      if (!cle_i && ale_i) addr_o <= addr_o + 1;
      else if (!cle_i) bytes_o <= bytes_o + 1;
      else if (io_i == 8'hFF) begin
        if (!in_rst) begin
          busy <= 6;
          arr <= 6;
        end
        in_rst <= 1'b1;
        stat_mode <= 1'b0;
        cf <= 1'b0;
        pf <= 1'b0;
        cache <= 1'b0;
      end
      else if (io_i == 8'h70) stat_mode <= 1'b1;
      else if (busy == 0 && (arr == 0 || cache)) begin
        stat_mode <= 1'b0;
        in_rst <= 1'b0;
        if (io_i == 8'h80 || io_i == 8'h60) begin
          bytes_o <= 0;
          addr_o <= 0;
        end
        if (io_i == 8'h15 || io_i == 8'h10 || io_i == 8'hD0) begin
          pf <= cf;
          cf <= fail_i || !wp_n_i;
          cache <= (io_i == 8'h15) || (io_i == 8'h10 && cache);
          arr <= arr + 10;
          // new cache data waits for the pending array program
          busy <= (io_i == 8'h15) ? arr + 2 : arr + 10;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: self-checking bench for the flash host sequencer
// Assumes: device model on the far side of the flash pins
// Notes:   column address held at zero; only sequencing is judged
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [2:0]  c;
    logic [23:0] r;
    logic [11:0] n;
    logic        f, x, ef, epf;
    logic [3:0]  na;
  } row_type;
  logic        clk_i = 0, resetn_i = 0, op_valid_i = 0, write_enable_i = 1;
  logic        wr_valid_i = 0, fail_inj = 0, got_ref;
  logic [2:0]  op_code_i = 0;
  logic [23:0] row_i = 0;
  logic [15:0] col_i = 0;
  logic [11:0] length_i = 0;
  logic [7:0]  wr_data_i = 0, io_o, io_i, status_o;
  logic        op_ready_o, wr_ready_o, done_o, refused_o, fail_o, prior_fail_o, protected_o;
  logic        ce_n_o, cle_o, ale_o, we_n_o, re_n_o, wp_n_o, io_oe_o, rb;
  int          miscompares = 0, comparisons = 0, cycles = 0, i, byte_cnt, addr_cnt;
  row_type     rows [12];
  nand_cache_host u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .row_i(row_i), .col_i(col_i), .length_i(length_i),
    .write_enable_i(write_enable_i), .op_ready_o(op_ready_o), .wr_data_i(wr_data_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .done_o(done_o), .refused_o(refused_o),
    .status_o(status_o), .fail_o(fail_o), .prior_fail_o(prior_fail_o),
    .protected_o(protected_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
    .re_n_o(re_n_o), .wp_n_o(wp_n_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i),
    .ready_busy_line_i(rb));
  nand_dev_model u_dev (.clk_i(clk_i), .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o),
    .we_n_i(we_n_o), .re_n_i(re_n_o), .wp_n_i(wp_n_o), .fail_i(fail_inj), .io_i(io_o),
    .io_o(io_i), .rb_o(rb), .bytes_o(byte_cnt), .addr_o(addr_cnt));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (wr_valid_i && wr_ready_o) wr_data_i <= wr_data_i + 8'h01;
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic do_op(input logic [2:0] c, input logic [23:0] r, input logic [11:0] n);
    do @(negedge clk_i); while (op_ready_o !== 1'b1);
    @(posedge clk_i);
    op_code_i <= c;
    row_i <= r;
    length_i <= n;
    op_valid_i <= 1'b1;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    do @(negedge clk_i); while (done_o !== 1'b1 && refused_o !== 1'b1);
    got_ref = refused_o;
  endtask
  // hang guard, well above the longest expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      final_report;
    end
  end
  // the host must drive the bus on write strobes and release it on read strobes
  always @(negedge clk_i) begin
    if (!we_n_o) chk("oe_write", 1, io_oe_o);
    if (!re_n_o) chk("oe_read", 0, io_oe_o);
  end
  initial begin
    rows = '{'{3'h0, 24'h000040, 12'h004, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5},
             '{3'h0, 24'h000041, 12'h003, 1'b1, 1'b0, 1'b1, 1'b0, 4'h5},
             '{3'h0, 24'h000080, 12'h004, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0},
             '{3'h2, 24'h000042, 12'h002, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5},
             '{3'h3, 24'h000100, 12'h000, 1'b1, 1'b0, 1'b1, 1'b0, 4'h3},
             '{3'h3, 24'h000140, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3},
             '{3'h1, 24'h000200, 12'h840, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5},
             '{3'h6, 24'h000000, 12'h001, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0},
             '{3'h0, 24'h000300, 12'h000, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0},
             '{3'h0, 24'h000300, 12'h841, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0},
             '{3'h5, 24'h000000, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0},
             '{3'h4, 24'h000000, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0}};
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    wr_valid_i <= 1'b1;
    for (i = 0; i < 12; i++) begin
      fail_inj = rows[i].f;
      do_op(rows[i].c, rows[i].r, rows[i].n);
      chk("refused", rows[i].x, got_ref);
      if (!rows[i].x) begin
        chk("fail", rows[i].ef, fail_o);
        if (rows[i].c != 3'h1) chk("prior", rows[i].epf, prior_fail_o);
        chk("reserved", 0, status_o[4:2]);
        chk("protected", 0, protected_o);
        if (rows[i].na != 0) chk("addr_cycles", rows[i].na, addr_cnt);
        if (rows[i].c < 3'h3) chk("data_bytes", rows[i].n, byte_cnt);
      end
    end
    fail_inj = 1'b0;
    for (i = 0; i < 64; i++) begin
      do_op(3'h0, 24'h000400 + i, 12'h001);
      chk("page_taken", 0, got_ref);
    end
    do_op(3'h0, 24'h000400, 12'h001);
    chk("page_65", 1, got_ref);
    do_op(3'h4, 24'h000000, 12'h000);
    chk("reset_status", 0, status_o);
    @(posedge clk_i) write_enable_i <= 1'b0;
    do_op(3'h3, 24'h000500, 12'h000);
    chk("protected", 1, protected_o);
    chk("protect_fail", 1, fail_o);
    // abort an erase in its setup cycle by reset; pins idle, order port reopens
    do @(negedge clk_i); while (op_ready_o !== 1'b1);
    @(posedge clk_i) op_valid_i <= 1'b1;
    @(posedge clk_i) op_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i) resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("reset_ce_n", 1, ce_n_o);
    chk("reset_we_n", 1, we_n_o);
    chk("reset_status", 0, status_o);
    chk("reset_op_ready", 0, op_ready_o);
    @(negedge clk_i);
    chk("release_op_ready", 1, op_ready_o);
    do_op(3'h5, 24'h000000, 12'h000);
    chk("status_after_reset", 0, got_ref);
    chk("protected_after_reset", 1, protected_o);
    final_report;
  end
endmodule
`default_nettype wire
